// ===== src/bsfu_top.sv
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module bsfu_top #(
    parameter int STACK_DEPTH = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core state
    output logic busy,
    output logic [7:0] status_q
);

    localparam int SPW = $clog2(STACK_DEPTH);

    typedef struct packed {
        bsfu_pkg::bsfu_state_t state;
        bsfu_pkg::bsfu_op_t op;
        logic [2:0] bsel;
        logic [2:0] sel;
        logic cnt;
        logic [7:0] status_register;
        logic [7:0][7:0] wregs;
        logic [7:0][7:0] io;
        logic [STACK_DEPTH-1:0][7:0] stack;
        logic [SPW:0] depth;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } bsfu_st_t;

    bsfu_st_t st_q;
    bsfu_st_t st_next;

    logic is_cmd;
    logic is_status;
    logic is_info;
    logic is_wreg;
    logic is_io;
    logic hit;
    logic setup;
    logic access;
    logic idle;
    logic is_stack;
    logic op_last;
    logic fire;
    logic [7:0] cur_reg;
    logic [7:0] cur_io;
    logic [7:0] bit_mask;
    logic [SPW:0] depth_dec;
    logic [7:0] alu_in;
    logic [7:0] alu_res;
    logic alu_wr;
    logic [7:0] alu_status_register;
    logic [31:0] rd_word;

    // Address decode; only aligned words answer
    assign is_cmd = (paddr == bsfu_pkg::ADDR_CMD);
    assign is_status = (paddr == bsfu_pkg::ADDR_STATUS);
    assign is_info = (paddr == bsfu_pkg::ADDR_INFO);
    assign is_wreg = (paddr[7:5] == bsfu_pkg::ADDR_WREG_BASE[7:5])
        && (paddr[1:0] == 2'b00);
    assign is_io = (paddr[7:5] == bsfu_pkg::ADDR_IO_BASE[7:5])
        && (paddr[1:0] == 2'b00);
    assign hit = is_cmd | is_status | is_info | is_wreg | is_io;
    assign setup = psel & ~penable;
    assign access = psel & penable & st_q.pready;

    // Execution helpers
    assign idle = (st_q.state == bsfu_pkg::st_idle);
    assign is_stack = (st_q.op == bsfu_pkg::stack_push_op)
        || (st_q.op == bsfu_pkg::stack_pop_op);
    assign op_last = is_stack ? 1'(bsfu_pkg::STACK_OP_CYCLES - 1)
        : 1'(bsfu_pkg::BASIC_OP_CYCLES - 1);
    assign fire = (st_q.state == bsfu_pkg::st_exec) && (st_q.cnt == op_last);
    assign cur_reg = st_q.wregs[st_q.sel];
    assign cur_io = st_q.io[st_q.sel];
    assign bit_mask = 8'h01 << st_q.bsel;
    assign depth_dec = st_q.depth - 1'b1;
    assign alu_in = ((st_q.op == bsfu_pkg::io_bit_set_op)
        || (st_q.op == bsfu_pkg::io_bit_clear_op)) ? cur_io : cur_reg;

    bsfu_alu u_alu (
        .op(st_q.op),
        .bsel(st_q.bsel),
        .operand(alu_in),
        .status_register_in(st_q.status_register),
        .result(alu_res),
        .wr_en(alu_wr),
        .status_register_out(alu_status_register)
    );

    // Read mux, sampled in the setup cycle
    always_comb begin
        rd_word = 32'h0000_0000;
        if (is_cmd) begin
            rd_word[bsfu_pkg::CMD_OP_LSB +: 5] = st_q.op;
            rd_word[bsfu_pkg::CMD_BIT_LSB +: 3] = st_q.bsel;
            rd_word[bsfu_pkg::CMD_SEL_LSB +: 3] = st_q.sel;
        end else if (is_status) begin
            rd_word[7:0] = st_q.status_register;
        end else if (is_info) begin
            rd_word[bsfu_pkg::INFO_BUSY_BIT] = ~idle;
            rd_word[bsfu_pkg::INFO_DEPTH_LSB +: SPW + 1] = st_q.depth;
        end else if (is_wreg) begin
            rd_word[7:0] = st_q.wregs[paddr[4:2]];
        end else if (is_io) begin
            rd_word[7:0] = st_q.io[paddr[4:2]];
        end
    end

    // Next state: bus slave and instruction sequencer
    always_comb begin
        st_next = st_q;
        // Answer one cycle after setup, so every access has one wait-free
        // access phase; read data is a snapshot from the setup cycle
        st_next.pready = setup;
        st_next.pslverr = setup & ~hit;
        if (setup) begin
            st_next.prdata = rd_word;
        end
        // Writes only land while idle, so they never race an instruction
        if (access && pwrite && hit && idle) begin
            if (is_cmd) begin
                st_next.op = bsfu_pkg::bsfu_op_t'(
                    pwdata[bsfu_pkg::CMD_OP_LSB +: 5]);
                st_next.bsel = pwdata[bsfu_pkg::CMD_BIT_LSB +: 3];
                st_next.sel = pwdata[bsfu_pkg::CMD_SEL_LSB +: 3];
                st_next.cnt = 1'b0;
                st_next.state = bsfu_pkg::st_exec;
            end else if (is_status) begin
                st_next.status_register = pwdata[7:0];
            end else if (is_wreg) begin
                st_next.wregs[paddr[4:2]] = pwdata[7:0];
            end else if (is_io) begin
                st_next.io[paddr[4:2]] = pwdata[7:0];
            end
        end
        // Instruction execution
        unique case (st_q.state)
            bsfu_pkg::st_idle: ;
            bsfu_pkg::st_exec: begin
                if (!fire) begin
                    st_next.cnt = 1'b1;
                end else begin
                    st_next.state = bsfu_pkg::st_idle;
                    if (st_q.op == bsfu_pkg::stack_push_op) begin
                        // A push onto a full stack is dropped
                        if (st_q.depth != (SPW + 1)'(STACK_DEPTH)) begin
                            st_next.stack[st_q.depth[SPW-1:0]] =
                                cur_reg;
                            st_next.depth = st_q.depth + 1'b1;
                        end
                    end else if (st_q.op == bsfu_pkg::stack_pop_op) begin
                        // A pop from an empty stack is dropped
                        if (st_q.depth != '0) begin
                            st_next.wregs[st_q.sel] =
                                st_q.stack[depth_dec[SPW-1:0]];
                            st_next.depth = depth_dec;
                        end
                    end else if (alu_in == cur_io && !alu_wr) begin
                        st_next.status_register = alu_status_register;
                    end else begin
                        st_next.status_register = alu_status_register;
                        if (alu_wr && ((st_q.op == bsfu_pkg::io_bit_set_op)
                            || (st_q.op == bsfu_pkg::io_bit_clear_op))) begin
                            st_next.io[st_q.sel] = alu_res;
                        end else if (alu_wr) begin
                            st_next.wregs[st_q.sel] = alu_res;
                        end
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.state <= bsfu_pkg::st_idle;
            st_q.status_register <= bsfu_pkg::STATUS_REGISTER_RST;
        end else begin
            st_q <= st_next;
        end
    end

    // Outputs straight from state bits
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign busy = st_q.state[1];
    assign status_q = st_q.status_register;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stack_two_cycles: assert property (
        (st_q.state == bsfu_pkg::st_exec && !st_q.cnt && is_stack)
        |=> (busy && $stable(st_q.status_register)) ##1 (!busy && $stable(st_q.status_register)))
        else $error("stack op not two cycles or flags moved");

    a_io_bit_set: assert property (
        (fire && st_q.op == bsfu_pkg::io_bit_set_op)
        |=> cur_io == ($past(cur_io) | bit_mask) && $stable(st_q.status_register))
        else $error("io bit set wrong");

    a_left_shift_res: assert property (
        (fire && st_q.op == bsfu_pkg::logical_left_shift_op)
        |=> cur_reg == 8'($past(cur_reg) << 1)
        && st_q.status_register[bsfu_pkg::FLAG_C] == $past(cur_reg[7]))
        else $error("left shift result or carry wrong");

    a_rotate_left_res: assert property (
        (fire && st_q.op == bsfu_pkg::carry_rotate_left_op)
        |=> cur_reg == {$past(cur_reg[6:0]), $past(st_q.status_register[0])}
        && st_q.status_register[bsfu_pkg::FLAG_C] == $past(cur_reg[7]))
        else $error("rotate left wrong");

    a_arith_shift_res: assert property (
        (fire && st_q.op == bsfu_pkg::sign_keep_right_shift_op)
        |=> cur_reg == {$past(cur_reg[7]), $past(cur_reg[7:1])}
        && st_q.status_register[bsfu_pkg::FLAG_S] == $past(st_q.status_register[4]))
        else $error("arithmetic shift wrong");

    a_nibble_swap_res: assert property (
        (fire && st_q.op == bsfu_pkg::nibble_swap_op)
        |=> cur_reg == {$past(cur_reg[3:0]), $past(cur_reg[7:4])}
        && $stable(st_q.status_register))
        else $error("nibble swap wrong");

    a_flag_set_one: assert property (
        (fire && st_q.op == bsfu_pkg::flag_set_op)
        |=> st_q.status_register == ($past(st_q.status_register) | bit_mask))
        else $error("flag set wrong");

    a_bit_store_t: assert property (
        (fire && st_q.op == bsfu_pkg::bit_to_transfer_flag_op)
        |=> st_q.status_register[bsfu_pkg::FLAG_T] == $past(cur_reg[st_q.bsel])
        && {st_q.status_register[7], st_q.status_register[5:0]}
        == $past({st_q.status_register[7], st_q.status_register[5:0]}))
        else $error("bit store wrong");

    a_bit_load_t: assert property (
        (fire && st_q.op == bsfu_pkg::transfer_flag_to_bit_op)
        |=> cur_reg[st_q.bsel] == $past(st_q.status_register[6]) && $stable(st_q.status_register))
        else $error("bit load wrong");

    a_carry_set_one: assert property (
        (st_q.state == bsfu_pkg::st_exec
        && st_q.op == bsfu_pkg::carry_set_op)
        |=> !busy && st_q.status_register == ($past(st_q.status_register) | 8'h01))
        else $error("carry set wrong or slow");

    a_zero_clear_one: assert property (
        (fire && st_q.op == bsfu_pkg::zero_clear_op)
        |=> st_q.status_register == ($past(st_q.status_register) & 8'hfd))
        else $error("zero clear wrong");

    a_irq_enable_one: assert property (
        (fire && st_q.op == bsfu_pkg::irq_enable_op)
        |=> st_q.status_register == ($past(st_q.status_register) | 8'h80))
        else $error("irq enable wrong");

    a_signed_clear_one: assert property (
        (fire && st_q.op == bsfu_pkg::signed_clear_op)
        |=> st_q.status_register == ($past(st_q.status_register) & 8'hef))
        else $error("signed clear wrong");

    a_io_clear_flags: assert property (
        (fire && st_q.op == bsfu_pkg::io_bit_clear_op)
        |=> $stable(st_q.status_register) && !cur_io[st_q.bsel])
        else $error("io bit clear wrong or flags moved");

endmodule

// ===== src/bsfu_pkg.sv
package bsfu_pkg;

    // Register byte offsets on the APB window
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INFO = 8'h08;
    localparam logic [7:0] ADDR_WREG_BASE = 8'h40;
    localparam logic [7:0] ADDR_IO_BASE = 8'h60;

    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BIT_LSB = 8;
    localparam int CMD_SEL_LSB = 12;

    // Info word fields
    localparam int INFO_BUSY_BIT = 0;
    localparam int INFO_DEPTH_LSB = 8;

    // Status register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // Reset values
    localparam logic [7:0] STATUS_REGISTER_RST = 8'h00;

    // Execution cycle counts
    localparam int STACK_OP_CYCLES = 2;
    localparam int BASIC_OP_CYCLES = 1;

    typedef enum logic [4:0] {
        no_op = 5'h00,
        stack_push_op = 5'h01,
        stack_pop_op = 5'h02,
        io_bit_set_op = 5'h03,
        io_bit_clear_op = 5'h04,
        logical_left_shift_op = 5'h05,
        logical_right_shift_op = 5'h06,
        carry_rotate_left_op = 5'h07,
        carry_rotate_right_op = 5'h08,
        sign_keep_right_shift_op = 5'h09,
        nibble_swap_op = 5'h0a,
        flag_set_op = 5'h0b,
        flag_clear_op = 5'h0c,
        bit_to_transfer_flag_op = 5'h0d,
        transfer_flag_to_bit_op = 5'h0e,
        carry_set_op = 5'h0f,
        carry_clear_op = 5'h10,
        negative_set_op = 5'h11,
        negative_clear_op = 5'h12,
        zero_set_op = 5'h13,
        zero_clear_op = 5'h14,
        irq_enable_op = 5'h15,
        irq_disable_op = 5'h16,
        signed_set_op = 5'h17,
        signed_clear_op = 5'h18
    } bsfu_op_t;

    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_exec = 2'b10
    } bsfu_state_t;

endpackage

// ===== src/bsfu_alu.sv
`timescale 1ns/10ps
module bsfu_alu (
    // Operation select
    input wire bsfu_pkg::bsfu_op_t op,
    input wire logic [2:0] bsel,
    // Operand and flags in
    input wire logic [7:0] operand,
    input wire logic [7:0] status_register_in,
    // Result
    output logic [7:0] result,
    output logic wr_en,
    output logic [7:0] status_register_out
);

    logic shift;
    logic carry;

    // One instruction of the group, purely combinational
    always_comb begin
        result = operand;
        wr_en = 1'b0;
        status_register_out = status_register_in;
        shift = 1'b0;
        carry = status_register_in[bsfu_pkg::FLAG_C];
        unique case (op)
            bsfu_pkg::logical_left_shift_op: begin
                result = {operand[6:0], 1'b0};
                carry = operand[7];
                shift = 1'b1;
            end
            bsfu_pkg::logical_right_shift_op: begin
                result = {1'b0, operand[7:1]};
                carry = operand[0];
                shift = 1'b1;
            end
            bsfu_pkg::carry_rotate_left_op: begin
                result = {operand[6:0], status_register_in[bsfu_pkg::FLAG_C]};
                carry = operand[7];
                shift = 1'b1;
            end
            bsfu_pkg::carry_rotate_right_op: begin
                result = {status_register_in[bsfu_pkg::FLAG_C], operand[7:1]};
                carry = operand[0];
                shift = 1'b1;
            end
            bsfu_pkg::sign_keep_right_shift_op: begin
                result = {operand[7], operand[7:1]};
                carry = operand[0];
                shift = 1'b1;
            end
            bsfu_pkg::nibble_swap_op: begin
                result = {operand[3:0], operand[7:4]};
                wr_en = 1'b1;
            end
            bsfu_pkg::io_bit_set_op: begin
                result[bsel] = 1'b1;
                wr_en = 1'b1;
            end
            bsfu_pkg::io_bit_clear_op: begin
                result[bsel] = 1'b0;
                wr_en = 1'b1;
            end
            bsfu_pkg::flag_set_op: status_register_out[bsel] = 1'b1;
            bsfu_pkg::flag_clear_op: status_register_out[bsel] = 1'b0;
            bsfu_pkg::bit_to_transfer_flag_op: begin
                status_register_out[bsfu_pkg::FLAG_T] = operand[bsel];
            end
            bsfu_pkg::transfer_flag_to_bit_op: begin
                result[bsel] = status_register_in[bsfu_pkg::FLAG_T];
                wr_en = 1'b1;
            end
            bsfu_pkg::carry_set_op:
                status_register_out[bsfu_pkg::FLAG_C] = 1'b1;
            bsfu_pkg::carry_clear_op:
                status_register_out[bsfu_pkg::FLAG_C] = 1'b0;
            bsfu_pkg::negative_set_op:
                status_register_out[bsfu_pkg::FLAG_N] = 1'b1;
            bsfu_pkg::negative_clear_op:
                status_register_out[bsfu_pkg::FLAG_N] = 1'b0;
            bsfu_pkg::zero_set_op: status_register_out[bsfu_pkg::FLAG_Z] = 1'b1;
            bsfu_pkg::zero_clear_op:
                status_register_out[bsfu_pkg::FLAG_Z] = 1'b0;
            bsfu_pkg::irq_enable_op:
                status_register_out[bsfu_pkg::FLAG_I] = 1'b1;
            bsfu_pkg::irq_disable_op:
                status_register_out[bsfu_pkg::FLAG_I] = 1'b0;
            bsfu_pkg::signed_set_op:
                status_register_out[bsfu_pkg::FLAG_S] = 1'b1;
            bsfu_pkg::signed_clear_op:
                status_register_out[bsfu_pkg::FLAG_S] = 1'b0;
            // Push, pop, no-op and unused codes leave everything alone
            default: ;
        endcase
        // Shifts touch Z, C, N and V only; S is left as it was
        if (shift) begin
            wr_en = 1'b1;
            status_register_out[bsfu_pkg::FLAG_C] = carry;
            status_register_out[bsfu_pkg::FLAG_N] = result[7];
            status_register_out[bsfu_pkg::FLAG_V] = result[7] ^ carry;
            status_register_out[bsfu_pkg::FLAG_Z] = (result == 8'h00);
        end
    end

endmodule

// ===== tb/bit_shift_flag_unit_tb_top.sv
`timescale 1ns/10ps
module bit_shift_flag_unit_tb_top;
    // Design ports
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic busy;
    logic [7:0] status_q;
    // Bench bookkeeping
    int failures;
    int compares;
    int busy_cnt;
    logic [31:0] rd;
    logic err;
    logic [7:0] exp_v;
    logic [15:0] m;
    // Working register 3, 2, 5, 6, 7 and I/O location 3
    localparam logic [7:0] R3 = bsfu_pkg::ADDR_WREG_BASE + 8'h0c;
    localparam logic [7:0] R2 = bsfu_pkg::ADDR_WREG_BASE + 8'h08;
    localparam logic [7:0] R5 = bsfu_pkg::ADDR_WREG_BASE + 8'h14;
    localparam logic [7:0] R6 = bsfu_pkg::ADDR_WREG_BASE + 8'h18;
    localparam logic [7:0] R7 = bsfu_pkg::ADDR_WREG_BASE + 8'h1c;
    localparam logic [7:0] IO3 = bsfu_pkg::ADDR_IO_BASE + 8'h0c;
    localparam logic [7:0] ST = bsfu_pkg::ADDR_STATUS;
    bsfu_pkg::bsfu_op_t sh_ops [5] = '{bsfu_pkg::logical_left_shift_op,
        bsfu_pkg::logical_right_shift_op, bsfu_pkg::carry_rotate_left_op,
        bsfu_pkg::carry_rotate_right_op, bsfu_pkg::sign_keep_right_shift_op};
    bsfu_pkg::bsfu_op_t fl_ops [10] = '{bsfu_pkg::carry_set_op,
        bsfu_pkg::carry_clear_op, bsfu_pkg::negative_set_op,
        bsfu_pkg::negative_clear_op, bsfu_pkg::zero_set_op,
        bsfu_pkg::zero_clear_op, bsfu_pkg::irq_enable_op,
        bsfu_pkg::irq_disable_op, bsfu_pkg::signed_set_op,
        bsfu_pkg::signed_clear_op};
    logic [2:0] fbit [5] = '{bsfu_pkg::FLAG_C, bsfu_pkg::FLAG_N,
        bsfu_pkg::FLAG_Z, bsfu_pkg::FLAG_I, bsfu_pkg::FLAG_S};
    logic [7:0] vals [4] = '{8'h81, 8'h01, 8'h80, 8'h00};
    logic [7:0] pres [2] = '{8'hd9, 8'h26};

    bsfu_top #(.STACK_DEPTH(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy),
        .status_q(status_q)
    );

    // 25 MHz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Counts execution cycles seen with busy high
    always @(posedge pclk) begin
        if (busy === 1'b1) busy_cnt++;
    end

    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; an idle edge after it keeps strobes apart
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // No assumed latency; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task rdchk(input string what, input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(what, e, rd[7:0]);
    endtask

    // Load a working register or I/O location, then the status register
    task prep(input logic [7:0] a, input logic [7:0] v, input logic [7:0] s);
        apb(1'b1, a, {24'h0, v});
        apb(1'b1, ST, {24'h0, s});
    endtask

    // Command write, then wait on busy under a bound, sampled at mid-cycle
    task exec(input bsfu_pkg::bsfu_op_t op, input logic [2:0] b,
              input logic [2:0] sel);
        int n;
        busy_cnt = 0;
        apb(1'b1, bsfu_pkg::ADDR_CMD, {17'h0, sel, 1'b0, b, 3'h0, op});
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (busy !== 1'b0 && n < 20);
        if (n >= 20) failures++;
        @(posedge pclk);
    endtask

    // Reference shift results: C is the bit shifted out, V = N xor C
    function automatic logic [15:0] model(input bsfu_pkg::bsfu_op_t op,
                                          input logic [7:0] d,
                                          input logic [7:0] s);
        logic [7:0] r;
        logic c;
        c = d[0];
        case (op)
            bsfu_pkg::logical_left_shift_op: begin
                r = {d[6:0], 1'b0};
                c = d[7];
            end
            bsfu_pkg::logical_right_shift_op: r = {1'b0, d[7:1]};
            bsfu_pkg::carry_rotate_left_op: begin
                r = {d[6:0], s[0]};
                c = d[7];
            end
            bsfu_pkg::carry_rotate_right_op: r = {s[0], d[7:1]};
            default: r = {d[7], d[7:1]};
        endcase
        s[bsfu_pkg::FLAG_C] = c;
        s[bsfu_pkg::FLAG_Z] = (r == 8'h00);
        s[bsfu_pkg::FLAG_N] = r[7];
        s[bsfu_pkg::FLAG_V] = r[7] ^ c;
        return {s, r};
    endfunction

    task summarize;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge pclk);
        failures++;
        summarize();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        compares = 0;
        busy_cnt = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("status after reset", 8'h00, status_q);
        // Shifts and rotates, both carry values, untouched flags both ways
        foreach (sh_ops[i]) begin
            foreach (vals[j]) begin
                foreach (pres[k]) begin
                    prep(R3, vals[j], pres[k]);
                    exec(sh_ops[i], 3'h0, 3'h3);
                    m = model(sh_ops[i], vals[j], pres[k]);
                    rdchk("shift result", R3, m[7:0]);
                    chk("shift flags", m[15:8],
                        status_q);
                end
            end
        end
        // Dedicated flag instructions from all-clear and all-set
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 10; i++) begin
                exp_v = (p == 0) ? 8'h00 : 8'hff;
                apb(1'b1, ST, {24'h0, exp_v});
                exec(fl_ops[i], 3'h0, 3'h0);
                exp_v[fbit[i / 2]] = ~i[0];
                chk("flag op", exp_v,
                    status_q);
                chk("flag op cycles", 8'h01, busy_cnt[7:0]);
            end
        end
        // Generic flag set and clear on every status bit
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, ST, 32'h0);
            exec(bsfu_pkg::flag_set_op, 3'(s), 3'h0);
            chk("flag set", 8'h01 << s, status_q);
            apb(1'b1, ST, 32'hff);
            exec(bsfu_pkg::flag_clear_op, 3'(s), 3'h0);
            chk("flag clear", ~(8'h01 << s), status_q);
        end
        // Nibble swap leaves flags alone
        prep(R3, 8'h3c, 8'h5a);
        exec(bsfu_pkg::nibble_swap_op, 3'h0, 3'h3);
        rdchk("swap result", R3, 8'hc3);
        chk("swap flags", 8'h5a, status_q);
        // Bit store into the transfer flag, both polarities
        prep(R3, 8'h20, 8'h00);
        exec(bsfu_pkg::bit_to_transfer_flag_op, 3'h5, 3'h3);
        chk("store one", 8'h40, status_q);
        prep(R3, 8'h20, 8'hff);
        exec(bsfu_pkg::bit_to_transfer_flag_op, 3'h4, 3'h3);
        chk("store zero", 8'hbf, status_q);
        // Bit load from the transfer flag at both ends of the byte
        prep(R3, 8'h00, 8'h40);
        exec(bsfu_pkg::transfer_flag_to_bit_op, 3'h7, 3'h3);
        rdchk("load one", R3, 8'h80);
        chk("load flags", 8'h40, status_q);
        prep(R3, 8'hff, 8'hbf);
        exec(bsfu_pkg::transfer_flag_to_bit_op, 3'h0, 3'h3);
        rdchk("load zero", R3, 8'hfe);
        // I/O bit set and clear
        prep(IO3, 8'h5a, 8'ha5);
        exec(bsfu_pkg::io_bit_set_op, 3'h0, 3'h3);
        rdchk("io set", IO3, 8'h5b);
        exec(bsfu_pkg::io_bit_clear_op, 3'h6, 3'h3);
        rdchk("io clear", IO3, 8'h1b);
        chk("io flags", 8'ha5, status_q);
        // Stack is last in first out; popping an empty stack changes nothing
        prep(R2, 8'ha5, 8'h3c);
        exec(bsfu_pkg::stack_push_op, 3'h0, 3'h2);
        chk("push cycles", 8'h02, busy_cnt[7:0]);
        apb(1'b1, R2, 32'h5a);
        exec(bsfu_pkg::stack_push_op, 3'h0, 3'h2);
        // Two entries on the stack and the engine idle
        apb(1'b0, bsfu_pkg::ADDR_INFO, 32'h0);
        chk("stack depth", 8'h02, rd[15:8]);
        chk("info idle", 8'h00, rd[7:0]);
        exec(bsfu_pkg::stack_pop_op, 3'h0, 3'h5);
        chk("pop cycles", 8'h02, busy_cnt[7:0]);
        exec(bsfu_pkg::stack_pop_op, 3'h0, 3'h6);
        rdchk("pop last", R5, 8'h5a);
        rdchk("pop first", R6, 8'ha5);
        chk("stack flags", 8'h3c, status_q);
        apb(1'b1, R7, 32'h77);
        exec(bsfu_pkg::stack_pop_op, 3'h0, 3'h7);
        rdchk("empty pop", R7, 8'h77);
        // Fifth push onto a four-deep stack is dropped
        for (int q = 0; q < 5; q++) begin
            apb(1'b1, R2, 32'(q + 1));
            exec(bsfu_pkg::stack_push_op, 3'h0, 3'h2);
        end
        exec(bsfu_pkg::stack_pop_op, 3'h0, 3'h7);
        rdchk("full push dropped", R7, 8'h04);
        // Command word reads back as last written
        apb(1'b0, bsfu_pkg::ADDR_CMD, 32'h0);
        chk("cmd op", 8'h02, rd[7:0]);
        chk("cmd sel", 8'h70, rd[15:8]);
        // Unmapped and unaligned accesses answer with an error
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped error", 8'h01, {7'h0, err});
        apb(1'b0, 8'h41, 32'h0);
        chk("unaligned error", 8'h01, {7'h0, err});
        summarize();
    end
endmodule
